// ==== rtl/sdacp_host.sv ====
// How it works
// - user codes sent as two's complement
// - in strobed mode, sync returns high before strobe low
// - strobe high before next sync low
// - serial clock never above 5 MHz
`timescale 1ns/1ps
`include "sdacp_regs.svh"

module sdacp_host #(
  parameter int HALF_CYC = `SDACP_SCLK_HALF_CYC,
  parameter int SETUP_CYC = `SDACP_T2_CYC,
  parameter int PULSE_CYC = `SDACP_T7_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // user stream, two's complement codes
  input wire logic code_valid_in,
  input wire logic [11:0] code_data_in,
  output logic code_ready_out,
  // mode: high selects automatic transfer (strobe held low while sync is low)
  input wire logic auto_mode_in,
  // status
  output logic busy_out,
  output logic word_done_out,
  // converter pins
  output logic sclk_out,
  output logic sync_n_out,
  output logic serial_data_input_out,
  output logic load_latch_strobe_n_out
);

  // ==========================================================
  // state
  sdacp_pkg::sdacp_regs_t q_r;
  sdacp_pkg::sdacp_regs_t q_nxt;
  logic push;
  logic pop;
  logic done_nxt;
  logic done_r;

  function automatic logic [3:0] cyc4(input int n);
    cyc4 = (n < 1) ? 4'h1 : 4'(n);
  endfunction : cyc4

  // two-entry buffer: a slow link stalls the source, never drops words
  assign code_ready_out = ~q_r.b1_v;
  assign push = code_valid_in & code_ready_out;

  // ==========================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    pop = 1'b0;
    done_nxt = 1'b0;
    if (q_r.div != 4'h0) begin
      q_nxt.div = q_r.div - 4'h1;
    end
    case (q_r.state)
      sdacp_pkg::ST_IDLE: begin
        if (q_r.b0_v) begin
          pop = 1'b1;
          q_nxt.auto_m = auto_mode_in;
          // upper nibble padding, code in low 12 bits, msb first;
          // bit 15 (a zero) goes out now, the rest waits in the shifter
          q_nxt.shreg = {3'h0, q_r.buf0, 1'b0};
          // strobe already high here, so sync may drop
          q_nxt.load_n = ~auto_mode_in;
          q_nxt.sync_n = 1'b0;
          q_nxt.sclk = 1'b1;
          q_nxt.sdata = 1'b0;
          q_nxt.bits = 5'h00;
          q_nxt.busy = 1'b1;
          q_nxt.div = cyc4(SETUP_CYC);
          q_nxt.state = sdacp_pkg::ST_SETUP;
        end
      end
      sdacp_pkg::ST_SETUP, sdacp_pkg::ST_HIGH: begin
        if (q_r.div == 4'h0) begin
          // data already stands; it never moves with the falling edge
          q_nxt.sclk = 1'b0;
          q_nxt.bits = q_r.bits + 5'h01;
          q_nxt.div = cyc4(HALF_CYC);
          q_nxt.state = sdacp_pkg::ST_LOW;
        end
      end
      sdacp_pkg::ST_LOW: begin
        if (q_r.div == 4'h0) begin
          q_nxt.sclk = 1'b1;
          q_nxt.div = cyc4(HALF_CYC);
          if (q_r.bits == 5'(`SDACP_WORD_BITS)) begin
            q_nxt.state = sdacp_pkg::ST_GAP;
          end else begin
            q_nxt.state = sdacp_pkg::ST_HIGH;
            // next bit moves on the rise, a half period clear of the
            // falling sample on both sides for setup and hold
            q_nxt.sdata = q_r.shreg[15];
            q_nxt.shreg = {q_r.shreg[14:0], 1'b0};
          end
        end
      end
      sdacp_pkg::ST_GAP: begin
        if (q_r.div == 4'h0) begin
          // frame ends; in strobed mode sync is high no later than the strobe falls
          q_nxt.sync_n = 1'b1;
          if (q_r.auto_m) begin
            // device loaded itself on the sixteenth edge
            // strobe released so it is high before the next sync falls
            q_nxt.load_n = 1'b1;
            q_nxt.busy = 1'b0;
            done_nxt = 1'b1;
            q_nxt.state = sdacp_pkg::ST_IDLE;
          end else begin
            q_nxt.div = cyc4(PULSE_CYC);
            q_nxt.state = sdacp_pkg::ST_LOAD;
          end
        end
      end
      sdacp_pkg::ST_LOAD: begin
        // strobe falls one cycle after sync rose
        q_nxt.load_n = 1'b0;
        // pulse width is counted only once the strobe is low
        if (q_r.load_n) begin
          q_nxt.div = q_r.div;
        end
        if (q_r.div == 4'h0 && !q_r.load_n) begin
          q_nxt.load_n = 1'b1;
          q_nxt.busy = 1'b0;
          done_nxt = 1'b1;
          q_nxt.state = sdacp_pkg::ST_IDLE;
        end
      end
      default: begin
        q_nxt.state = sdacp_pkg::ST_IDLE;
      end
    endcase
    // buffer bookkeeping
    if (pop) begin
      q_nxt.buf0 = q_r.buf1;
      q_nxt.b0_v = q_r.b1_v | (push & q_r.b0_v);
      q_nxt.b1_v = 1'b0;
      if (push) begin
        if (q_r.b1_v) begin
          q_nxt.buf1 = code_data_in;
          q_nxt.b1_v = 1'b1;
        end else begin
          q_nxt.buf0 = code_data_in;
        end
      end
    end else if (push) begin
      if (q_r.b0_v) begin
        q_nxt.buf1 = code_data_in;
        q_nxt.b1_v = 1'b1;
      end else begin
        q_nxt.buf0 = code_data_in;
        q_nxt.b0_v = 1'b1;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      q_r <= '0;
      q_r.state <= sdacp_pkg::ST_IDLE;
      q_r.sclk <= 1'b1;
      q_r.sync_n <= 1'b1;
      q_r.load_n <= 1'b1;
      done_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      done_r <= done_nxt;
    end
  end

  assign sclk_out = q_r.sclk;
  assign sync_n_out = q_r.sync_n;
  assign serial_data_input_out = q_r.sdata;
  assign load_latch_strobe_n_out = q_r.load_n;
  assign busy_out = q_r.busy;
  assign word_done_out = done_r;

endmodule : sdacp_host

// ==== rtl/sdacp_pkg.sv ====
package sdacp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_GAP,
    ST_LOAD
  } sdacp_state_t;

  typedef struct packed {
    sdacp_state_t state;
    logic [3:0] div;
    logic [4:0] bits;
    logic [15:0] shreg;
    logic sclk;
    logic sync_n;
    logic load_n;
    logic sdata;
    logic [11:0] buf0;
    logic [11:0] buf1;
    logic b0_v;
    logic b1_v;
    logic auto_m;
    logic busy;
  } sdacp_regs_t;

endpackage : sdacp_pkg

// ==== rtl/sdacp_regs.svh ====
`ifndef SDACP_REGS_SVH
`define SDACP_REGS_SVH

// serial clock period limit: 200 ns min cycle, 5 MHz max rate
`define SDACP_SCLK_MIN_NS 200
`define SDACP_CLK_NS 40
// half period rounded up so the link never runs above 5 MHz
`define SDACP_SCLK_HALF_CYC \
  ((`SDACP_SCLK_MIN_NS / 2 + `SDACP_CLK_NS - 1) / `SDACP_CLK_NS)
// frame sync setup before first falling edge, 50 ns min
`define SDACP_T2_NS 50
`define SDACP_T2_CYC ((`SDACP_T2_NS + `SDACP_CLK_NS - 1) / `SDACP_CLK_NS)
// load strobe pulse width, 50 ns min
`define SDACP_T7_NS 50
`define SDACP_T7_CYC ((`SDACP_T7_NS + `SDACP_CLK_NS - 1) / `SDACP_CLK_NS)
`define SDACP_WORD_BITS 16
`define SDACP_CODE_BITS 12
// code points of the two's complement converter
`define SDACP_CODE_NEG_FS 12'h800
`define SDACP_CODE_POS_FS 12'h7FF
`define SDACP_CODE_ZERO 12'h000

`endif

// ==== verif/sdacp_dev.sv ====
`timescale 1ns/1ps
// ====
// converter port model, sampled after each edge settles
module sdacp_dev (
  input wire logic clk_sys_in,
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic serial_data_input_in,
  input wire logic ld_n_in,
  output logic [11:0] dac_out
);
  logic [15:0] sh = 16'h0000;
  logic [4:0] nb = 5'h00;
  logic sc = 1'b1;
  logic ld = 1'b1;
  initial dac_out = 12'h000;
  always @(posedge clk_sys_in) begin
    sc <= sclk_in;
    ld <= ld_n_in;
    if (sync_n_in) nb <= 5'h00;
    else if (sc && !sclk_in && nb < 5'h10) begin
      sh <= {sh[14:0], serial_data_input_in};
      nb <= nb + 5'h01;
      if (!ld_n_in && nb == 5'h0F) dac_out <= {sh[10:0], serial_data_input_in};
    end
    // only a transfer moves the output
    if (ld && !ld_n_in && sync_n_in) dac_out <= sh[11:0];
  end
endmodule : sdacp_dev

// ==== verif/sdacp_host_checker.sv ====
`timescale 1ns/1ps
// ====
// pin protocol checks
module sdacp_host_checker (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic busy_out,
  input wire logic sclk_out,
  input wire logic sync_n_out,
  input wire logic serial_data_input_out,
  input wire logic load_latch_strobe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic [4:0] nf_r;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || sync_n_out) nf_r <= 5'h00;
    else if ($fell(sclk_out)) nf_r <= nf_r + 5'h01;
  end
  property p_idle; sync_n_out |-> sclk_out; endproperty
  a_idle: assert property (p_idle) else $error("clock off frame");
  property p_setup;
    $fell(sync_n_out) |-> (busy_out && sclk_out) [*3];
  endproperty
  a_setup: assert property (p_setup) else $error("sync setup");
  property p_low; $fell(sclk_out) |-> !sclk_out [*4]; endproperty
  a_low: assert property (p_low) else $error("low phase");
  property p_high;
    $rose(sclk_out) && !sync_n_out |-> sclk_out [*4];
  endproperty
  a_high: assert property (p_high) else $error("high phase");
  property p_data;
    !sclk_out && !$past(sclk_out) |-> $stable(serial_data_input_out);
  endproperty
  a_data: assert property (p_data) else $error("data moved");
  property p_cnt; $rose(sync_n_out) |-> nf_r == 5'h10; endproperty
  a_cnt: assert property (p_cnt) else $error("fall count");
  property p_order;
    $fell(sync_n_out) |-> $past(load_latch_strobe_n_out);
  endproperty
  a_order: assert property (p_order) else $error("strobe order");
  property p_pulse;
    $fell(load_latch_strobe_n_out) && sync_n_out
      |-> $past(sync_n_out) ##0 !load_latch_strobe_n_out [*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe");
endmodule : sdacp_host_checker

bind sdacp_host sdacp_host_checker u_chk (.clk_sys_in, .srst_in, .busy_out,
  .sclk_out, .sync_n_out, .serial_data_input_out, .load_latch_strobe_n_out);

// ==== verif/sdacp_host_test.sv ====
`timescale 1ns/1ps
module sdacp_host_test;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic code_valid_in = 1'b0;
  logic [11:0] code_data_in = 12'h000;
  logic auto_mode_in = 1'b0;
  logic code_ready_out, busy_out, word_done_out, sclk_out, sync_n_out;
  logic serial_data_input_out, load_latch_strobe_n_out;
  logic full = 1'b0;
  logic [11:0] dac;
  int n_errors = 0;
  int checks = 0;
  sdacp_host DUT (.clk_sys_in, .srst_in, .code_valid_in, .code_data_in,
    .code_ready_out, .auto_mode_in, .busy_out, .word_done_out, .sclk_out,
    .sync_n_out, .serial_data_input_out, .load_latch_strobe_n_out);
  sdacp_dev u_dev (.clk_sys_in, .sclk_in(sclk_out), .sync_n_in(sync_n_out),
    .serial_data_input_in(serial_data_input_out), .ld_n_in(load_latch_strobe_n_out),
    .dac_out(dac));
  initial forever #20 clk_sys_in = ~clk_sys_in;
  // remembers that the buffer refused at least once
  always @(posedge clk_sys_in) if (code_ready_out === 1'b0) full <= 1'b1;
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // leading tick keeps valid from being set twice in one step
  task automatic push(input logic [11:0] c);
    tick();
    for (int i = 0; i < 400 && code_ready_out !== 1'b1; i++) tick();
    code_valid_in = 1'b1;
    code_data_in = c;
    tick();
    code_valid_in = 1'b0;
  endtask : push
  task automatic run(input logic am, input logic [11:0] q[4]);
    auto_mode_in = am;
    fork
      foreach (q[i]) push(q[i]);
      foreach (q[i]) begin
        for (int k = 0; k < 600 && word_done_out !== 1'b1; k++) tick();
        chk(dac, q[i]);
        tick();
      end
    join
  endtask : run
  task automatic t_strobed();
    run(1'b0, '{12'h800, 12'h7FF, 12'h000, 12'h5A3});
    chk({11'h000, full}, 12'h001);
  endtask : t_strobed
  task automatic t_auto();
    run(1'b1, '{12'h001, 12'hFFE, 12'h400, 12'hBCD});
  endtask : t_auto
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (16) tick();
    srst_in = 1'b0;
    t_strobed();
    t_auto();
    close_out();
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : sdacp_host_test
